// ===== core/indexing_sequence_input_decoder.sv
// How it works
// - Mode input ON selects program table mode 0, OFF selects jog/homing mode 1.
// - Mode 0 run input rising starts or resumes program, latching table choice.
// - Mode 0 run input falling stops the running program.
// - Mode 1 run input rising starts homing, falling cancels it.
// - Mode 1 forward input ON jogs forward, OFF stops jog.
// - Mode 1 reverse input ON jogs reverse, OFF stops jog.
// - Mode 0 forward, reverse, pick inputs form table choice bits 0, 1, 2.
// - Mode 1 pick input rising starts jog speed table operation.
// - Mode 0 reset rising resets program only while stopped; ignored while running.
// - Reset input rising clears the active fault in either mode.
// - Motor power follows the power request input.
// - Slowdown switch during homing drops homing to approach or creep speed.
// - Each general input can be remapped to any function by configuration.
// - Pulse reference pair decoded as sign+pulse, CW+CCW or quadrature.
// - Fault output opens (low) whenever an error is detected.
`timescale 1ns/1ps
`include "seq_input_defines.svh"
module indexing_sequence_input_decoder (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic general_input_0,
  input wire logic general_input_1,
  input wire logic general_input_2,
  input wire logic general_input_3,
  input wire logic general_input_4,
  input wire logic general_input_5,
  input wire logic general_input_6,
  input wire logic general_input_8,
  input wire logic [23:0] input_map,
  input wire seq_input_pkg::pulse_form_t pulse_form,
  input wire logic pulse_ref_input,
  input wire logic sign_ref_input,
  input wire logic error_detected,
  input wire logic approach_not_creep,
  output logic program_mode,
  output logic motor_power,
  output logic program_run,
  output logic program_start,
  output logic program_stop,
  output logic program_reset,
  output logic [2:0] start_table,
  output logic homing_active,
  output logic homing_start,
  output logic homing_cancel,
  output logic homing_slow_approach,
  output logic homing_slow_creep,
  output logic jog_forward,
  output logic jog_reverse,
  output logic jog_table_start,
  output logic jog_stop,
  output logic fault_clear,
  output logic fault_output,
  output logic step_up,
  output logic step_down
);
  // ----------------------------------------
  // Input capture and remap
  // ----------------------------------------
  logic [`NUM_PIN-1:0] pin_raw;
  logic [`NUM_PIN-1:0] pin_reg;
  logic [`NUM_FN-1:0] fn_now;
  logic [`NUM_FN-1:0] fn_reg;
  logic [`NUM_FN-1:0] fn_rise;
  logic [`NUM_FN-1:0] fn_fall;
  seq_input_pkg::motion_state_t state_reg;
  seq_input_pkg::motion_state_t state_next;
  logic fault_reg;
  logic slow_reg;
  logic mode0;
  assign pin_raw = {
    general_input_8,
    general_input_6,
    general_input_5,
    general_input_4,
    general_input_3,
    general_input_2,
    general_input_1,
    general_input_0
  };
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pin_reg <= '0;
    end else begin
      pin_reg <= pin_raw;
    end
  end
  genvar g;
  generate
    for (g = 0; g < `NUM_FN; g++) begin : g_map
      assign fn_now[g] = pin_reg[input_map[g*`MAP_FIELD_W +: `MAP_FIELD_W]];
    end
  endgenerate
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fn_reg <= '0;
    end else begin
      fn_reg <= fn_now;
    end
  end
  assign fn_rise = fn_now & ~fn_reg;
  assign fn_fall = ~fn_now & fn_reg;
  assign mode0 = fn_now[`FN_MODE];
  // ----------------------------------------
  // Motion state machine
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      seq_input_pkg::ST_IDLE: begin
        if (mode0) begin
          if (fn_rise[`FN_RUN]) begin
            state_next = seq_input_pkg::ST_PROG;
          end
        end else begin
          if (fn_rise[`FN_RUN]) begin
            state_next = seq_input_pkg::ST_HOME;
          end else if (fn_now[`FN_FWD]) begin
            state_next = seq_input_pkg::ST_JOG_FWD;
          end else if (fn_now[`FN_REV]) begin
            state_next = seq_input_pkg::ST_JOG_REV;
          end else if (fn_rise[`FN_PICK]) begin
            state_next = seq_input_pkg::ST_JOG_TABLE;
          end
        end
      end
      seq_input_pkg::ST_PROG: begin
        if (fn_fall[`FN_RUN] || !mode0) begin
          state_next = seq_input_pkg::ST_IDLE;
        end
      end
      seq_input_pkg::ST_HOME: begin
        if (fn_fall[`FN_RUN] || mode0) begin
          state_next = seq_input_pkg::ST_IDLE;
        end
      end
      seq_input_pkg::ST_JOG_FWD: begin
        if (!fn_now[`FN_FWD] || mode0) begin
          state_next = seq_input_pkg::ST_IDLE;
        end
      end
      seq_input_pkg::ST_JOG_REV: begin
        if (!fn_now[`FN_REV] || mode0) begin
          state_next = seq_input_pkg::ST_IDLE;
        end
      end
      seq_input_pkg::ST_JOG_TABLE: begin
        // Table jog runs while pick is held, so release ends it
        if (!fn_now[`FN_PICK] || mode0) begin
          state_next = seq_input_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = seq_input_pkg::ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= seq_input_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end
  // ----------------------------------------
  // Action pulses
  // ----------------------------------------
  // start pulse on entry
  // Start, stop and cancel pulses come from the state change itself, so a held input cannot repeat them
  always_ff @(posedge core_clk) begin
    if (reset) begin
      program_start <= 1'b0;
    end else begin
      program_start <= (state_reg != seq_input_pkg::ST_PROG) && (state_next == seq_input_pkg::ST_PROG);
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      program_stop <= 1'b0;
    end else begin
      program_stop <= (state_reg == seq_input_pkg::ST_PROG) && (state_next != seq_input_pkg::ST_PROG);
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      homing_start <= 1'b0;
    end else begin
      homing_start <= (state_reg != seq_input_pkg::ST_HOME) && (state_next == seq_input_pkg::ST_HOME);
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      homing_cancel <= 1'b0;
    end else begin
      homing_cancel <= (state_reg == seq_input_pkg::ST_HOME) && (state_next != seq_input_pkg::ST_HOME);
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      jog_table_start <= 1'b0;
    end else begin
      jog_table_start <= (state_reg != seq_input_pkg::ST_JOG_TABLE) &&
                         (state_next == seq_input_pkg::ST_JOG_TABLE);
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      jog_stop <= 1'b0;
    end else begin
      jog_stop <= ((state_reg == seq_input_pkg::ST_JOG_FWD) || (state_reg == seq_input_pkg::ST_JOG_REV) ||
                   (state_reg == seq_input_pkg::ST_JOG_TABLE)) && (state_next == seq_input_pkg::ST_IDLE);
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      start_table <= 3'h0;
    end else if (mode0 && fn_rise[`FN_RUN] && (state_reg == seq_input_pkg::ST_IDLE)) begin
      start_table <= {fn_now[`FN_PICK], fn_now[`FN_REV], fn_now[`FN_FWD]};
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      program_reset <= 1'b0;
    end else begin
      program_reset <= mode0 && fn_rise[`FN_RESET] && (state_reg != seq_input_pkg::ST_PROG);
    end
  end
  // ----------------------------------------
  // Fault, power and homing speed
  // ----------------------------------------
  // clear pulse any mode
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fault_clear <= 1'b0;
    end else begin
      fault_clear <= fn_rise[`FN_RESET];
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fault_reg <= 1'b0;
    end else if (error_detected) begin
      fault_reg <= 1'b1;
    end else if (fn_rise[`FN_RESET]) begin
      fault_reg <= 1'b0;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      slow_reg <= 1'b0;
    end else if (state_reg != seq_input_pkg::ST_HOME) begin
      slow_reg <= 1'b0;
    end else if (fn_now[`FN_SLOW]) begin
      slow_reg <= 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      motor_power <= 1'b0;
    end else begin
      motor_power <= fn_now[`FN_POWER];
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      program_mode <= 1'b0;
    end else begin
      program_mode <= mode0;
    end
  end
  // open on any error
  // Raw error joins the latch so the output opens without waiting a cycle for it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fault_output <= 1'b0;
    end else begin
      fault_output <= ~(fault_reg | error_detected);
    end
  end
  assign program_run = (state_reg == seq_input_pkg::ST_PROG);
  assign homing_active = (state_reg == seq_input_pkg::ST_HOME);
  assign jog_forward = (state_reg == seq_input_pkg::ST_JOG_FWD);
  assign jog_reverse = (state_reg == seq_input_pkg::ST_JOG_REV);
  assign homing_slow_approach = slow_reg & approach_not_creep;
  assign homing_slow_creep = slow_reg & ~approach_not_creep;
  // ----------------------------------------
  // Pulse reference
  // ----------------------------------------
  // pulse pair decode
  pulse_ref_decoder i_pulse_ref_decoder (
    .core_clk(core_clk),
    .reset(reset),
    .pulse_form(pulse_form),
    .pulse_ref_input(pulse_ref_input),
    .sign_ref_input(sign_ref_input),
    .step_up(step_up),
    .step_down(step_down)
  );
endmodule : indexing_sequence_input_decoder

// ===== core/seq_input_defines.svh
`ifndef SEQ_INPUT_DEFINES_SVH
`define SEQ_INPUT_DEFINES_SVH
`define FN_POWER 3'h0
`define FN_RUN 3'h1
`define FN_FWD 3'h2
`define FN_MODE 3'h3
`define FN_REV 3'h4
`define FN_PICK 3'h5
`define FN_RESET 3'h6
`define FN_SLOW 3'h7
`define NUM_FN 8
`define NUM_PIN 8
`define MAP_FIELD_W 3
`define PULSE_SIGN 2'h0
`define PULSE_CWCCW 2'h1
`define PULSE_QUAD 2'h2
`endif

// ===== core/seq_input_pkg.sv
package seq_input_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PROG = 3'b001,
    ST_HOME = 3'b010,
    ST_JOG_FWD = 3'b011,
    ST_JOG_REV = 3'b100,
    ST_JOG_TABLE = 3'b101
  } motion_state_t;
  typedef logic [2:0] fn_index_t;
  typedef logic [1:0] pulse_form_t;
endpackage : seq_input_pkg

// ===== core/pulse_ref_decoder.sv
`timescale 1ns/1ps
`include "seq_input_defines.svh"
module pulse_ref_decoder (
  input wire logic core_clk,
  input wire logic reset,
  input wire seq_input_pkg::pulse_form_t pulse_form,
  input wire logic pulse_ref_input,
  input wire logic sign_ref_input,
  output logic step_up,
  output logic step_down
);
  logic a_reg;
  logic b_reg;
  logic a_edge;
  logic b_edge;
  assign a_edge = pulse_ref_input & ~a_reg;
  assign b_edge = sign_ref_input & ~b_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      a_reg <= 1'b0;
      b_reg <= 1'b0;
    end else begin
      a_reg <= pulse_ref_input;
      b_reg <= sign_ref_input;
    end
  end
  always_ff @(posedge core_clk) begin
    if (reset) begin
      step_up <= 1'b0;
      step_down <= 1'b0;
    end else begin
      case (pulse_form)
        `PULSE_SIGN: begin
          step_up <= a_edge & ~sign_ref_input;
          step_down <= a_edge & sign_ref_input;
        end
        `PULSE_CWCCW: begin
          step_up <= a_edge & ~b_edge;
          step_down <= b_edge & ~a_edge;
        end
        `PULSE_QUAD: begin
          // Only A edges counted: a cheap x2 decode, one count per A change
          step_up <= (pulse_ref_input ^ a_reg) & (pulse_ref_input ^ sign_ref_input);
          step_down <= (pulse_ref_input ^ a_reg) & ~(pulse_ref_input ^ sign_ref_input);
        end
        default: begin
          step_up <= 1'b0;
          step_down <= 1'b0;
        end
      endcase
    end
  end
endmodule : pulse_ref_decoder

// ===== tb/seq_host_model.sv
`timescale 1ns/1ps
// ----------
// Host model
// ----------
// Takes the wanted levels at the rising edge and drives them at the next
// falling edge, so the bench never races the pins
module seq_host_model (
  input wire logic core_clk,
  input wire logic [7:0] want,
  output logic [7:0] pins
);
  logic [7:0] want_reg;
  initial pins = 8'h00;
  always @(posedge core_clk) want_reg <= want;
  always @(negedge core_clk) pins <= want_reg;
endmodule : seq_host_model

// ===== tb/indexing_sequence_input_decoder_checker.sv
`timescale 1ns/1ps
module indexing_sequence_input_decoder_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic general_input_0,
  input wire logic general_input_1,
  input wire logic general_input_2,
  input wire logic general_input_3,
  input wire logic general_input_6,
  input wire logic error_detected,
  input wire logic program_mode,
  input wire logic motor_power,
  input wire logic program_run,
  input wire logic program_start,
  input wire logic program_reset,
  input wire logic jog_forward,
  input wire logic fault_clear,
  input wire logic fault_output
);
  // ----------
  // Properties
  // ----------
  // Valid for the default pin map only
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_run_rise_mode0;
    $rose(general_input_1) && general_input_3 && program_mode && !program_run;
  endsequence
  property p_power_on; $rose(general_input_0) |-> ##[2:3] motor_power; endproperty
  property p_power_off; $fell(general_input_0) |-> ##[2:3] !motor_power; endproperty
  property p_mode; $rose(general_input_3) |-> ##[2:3] program_mode; endproperty
  property p_fault; error_detected |-> ##[1:3] !fault_output; endproperty
  property p_prog_start; s_run_rise_mode0 |-> ##[2:3] program_start; endproperty
  property p_start_run; program_start |-> program_run; endproperty
  property p_single; program_start |=> !program_start; endproperty
  property p_reset_idle; program_reset |-> !program_run; endproperty
  property p_jog_fwd; jog_forward |-> $past(general_input_2, 2) || $past(general_input_2, 3); endproperty
  property p_clear; fault_clear |-> $past(general_input_6, 2) || $past(general_input_6, 3); endproperty
  a_power_on: assert property (p_power_on) else $error("power not applied");
  a_power_off: assert property (p_power_off) else $error("power not removed");
  a_mode: assert property (p_mode) else $error("mode 0 not entered");
  a_fault: assert property (p_fault) else $error("fault output not opened");
  a_prog_start: assert property (p_prog_start) else $error("program not started");
  a_start_run: assert property (p_start_run) else $error("start without run");
  a_single: assert property (p_single) else $error("start pulse too long");
  a_reset_idle: assert property (p_reset_idle) else $error("reset while running");
  a_jog_fwd: assert property (p_jog_fwd) else $error("jog without input");
  a_clear: assert property (p_clear) else $error("clear without request");
endmodule : indexing_sequence_input_decoder_checker

// ===== tb/tb_indexing_sequence_input_decoder.sv
`timescale 1ns/1ps
module tb_indexing_sequence_input_decoder;
  logic core_clk, reset, pulse_ref_input, sign_ref_input, error_detected, approach_not_creep;
  logic [23:0] input_map;
  seq_input_pkg::pulse_form_t pulse_form;
  logic [7:0] want, pins;
  logic program_mode, motor_power, program_run, program_start, program_stop, program_reset;
  logic homing_active, homing_start, homing_cancel, homing_slow_approach, homing_slow_creep;
  logic jog_forward, jog_reverse, jog_table_start, jog_stop, fault_clear, fault_output, step_up, step_down;
  logic [2:0] start_table;
  int n_fail, cmp_count, n_start, n_reset, n_clear, n_table, n_up, n_dn, n_stop, n_hstart, n_hcancel, n_jstop;
  int s, r, c, h, j;
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  seq_host_model i_seq_host_model (.core_clk, .want, .pins);
  indexing_sequence_input_decoder i_indexing_sequence_input_decoder (.core_clk, .reset,
    .general_input_0(pins[0]), .general_input_1(pins[1]), .general_input_2(pins[2]), .general_input_3(pins[3]),
    .general_input_4(pins[4]), .general_input_5(pins[5]), .general_input_6(pins[6]), .general_input_8(pins[7]),
    .input_map, .pulse_form, .pulse_ref_input, .sign_ref_input, .error_detected, .approach_not_creep,
    .program_mode, .motor_power, .program_run, .program_start, .program_stop, .program_reset, .start_table,
    .homing_active, .homing_start, .homing_cancel, .homing_slow_approach, .homing_slow_creep, .jog_forward,
    .jog_reverse, .jog_table_start, .jog_stop, .fault_clear, .fault_output, .step_up, .step_down);
  // Pulses are counted so a doubled or lost one shows up
  always @(posedge core_clk) begin
    n_start += int'(program_start === 1'b1);
    n_reset += int'(program_reset === 1'b1);
    n_clear += int'(fault_clear === 1'b1);
    n_table += int'(jog_table_start === 1'b1);
    n_up += int'(step_up === 1'b1);
    n_dn += int'(step_down === 1'b1);
    n_stop += int'(program_stop === 1'b1);
    n_hstart += int'(homing_start === 1'b1);
    n_hcancel += int'(homing_cancel === 1'b1);
    n_jstop += int'(jog_stop === 1'b1);
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic go(input logic [7:0] w);
    want = w;
    repeat (5) @(negedge core_clk);
  endtask : go
  task automatic wrap_up();
    $display("fails=%0d compares=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  task automatic ab(input logic a, input logic b);
    pulse_ref_input = a;
    sign_ref_input = b;
    repeat (3) @(negedge core_clk);
  endtask : ab
  task automatic t_prog();
    go(8'h29);
    chk(8'(program_mode), 8'h01);
    s = n_start;
    r = n_reset;
    c = n_clear;
    h = n_stop;
    go(8'h2b);
    chk(8'(n_start - s), 8'h01);
    chk(8'(start_table), 8'h04);
    chk(8'(program_run), 8'h01);
    go(8'h6b);
    chk(8'(n_reset - r), 8'h00);
    go(8'h2b);
    go(8'h29);
    chk(8'(program_run), 8'h00);
    chk(8'(n_stop - h), 8'h01);
    go(8'h69);
    chk(8'(n_reset - r), 8'h01);
    chk(8'(n_clear - c), 8'h02);
    go(8'h1f);
    chk(8'(start_table), 8'h03);
    chk(8'(n_start - s), 8'h02);
    go(8'h01);
    chk(8'(program_run), 8'h00);
    chk(8'(n_stop - h), 8'h02);
  endtask : t_prog
  task automatic t_home();
    h = n_hstart;
    j = n_hcancel;
    go(8'h03);
    chk(8'(homing_active), 8'h01);
    chk(8'(program_mode), 8'h00);
    go(8'h87);
    chk(8'(jog_forward), 8'h00);
    chk(8'({homing_slow_approach, homing_slow_creep}), 8'h01);
    approach_not_creep = 1'b1;
    go(8'h83);
    chk(8'({homing_slow_approach, homing_slow_creep}), 8'h02);
    go(8'h01);
    approach_not_creep = 1'b0;
    chk(8'(homing_active), 8'h00);
    chk(8'(n_hstart - h), 8'h01);
    chk(8'(n_hcancel - j), 8'h01);
  endtask : t_home
  task automatic t_jog();
    j = n_jstop;
    s = n_table;
    go(8'h05);
    chk(8'(jog_forward), 8'h01);
    go(8'h01);
    chk(8'(jog_forward), 8'h00);
    go(8'h11);
    chk(8'(jog_reverse), 8'h01);
    go(8'h01);
    chk(8'(jog_reverse), 8'h00);
    go(8'h21);
    chk(8'(n_table - s), 8'h01);
    go(8'h01);
    chk(8'(n_jstop - j), 8'h03);
  endtask : t_jog
  task automatic t_fault();
    chk(8'(fault_output), 8'h01);
    error_detected = 1'b1;
    go(8'h01);
    chk(8'(fault_output), 8'h00);
    error_detected = 1'b0;
    go(8'h41);
    chk(8'(fault_output), 8'h01);
    error_detected = 1'b1;
    go(8'h01);
    go(8'h41);
    error_detected = 1'b0;
    go(8'h41);
    chk(8'(fault_output), 8'h00);
    go(8'h01);
    go(8'h41);
    chk(8'(fault_output), 8'h01);
    go(8'h01);
  endtask : t_fault
  task automatic t_misc();
    input_map = 24'hfac68f;
    go(8'h81);
    chk(8'(motor_power), 8'h01);
    go(8'h01);
    chk(8'(motor_power), 8'h00);
    input_map = 24'hfac688;
    go(8'h01);
    chk(8'(motor_power), 8'h01);
  endtask : t_misc
  task automatic t_pulse();
    s = n_up;
    r = n_dn;
    repeat (4) begin
      ab(1'b1, 1'b0);
      ab(1'b0, 1'b0);
    end
    repeat (2) begin
      ab(1'b0, 1'b1);
      ab(1'b0, 1'b0);
    end
    chk(8'(n_up - s), 8'h04);
    chk(8'(n_dn - r), 8'h02);
    pulse_form = 2'h0;
    s = n_up;
    r = n_dn;
    ab(1'b0, 1'b1);
    repeat (2) begin
      ab(1'b1, 1'b1);
      ab(1'b0, 1'b1);
    end
    ab(1'b1, 1'b0);
    ab(1'b0, 1'b0);
    chk(8'(n_dn - r), 8'h02);
    chk(8'(n_up - s), 8'h01);
    pulse_form = 2'h2;
    s = n_up;
    r = n_dn;
    ab(1'b1, 1'b0);
    ab(1'b1, 1'b1);
    ab(1'b0, 1'b1);
    ab(1'b0, 1'b0);
    chk(8'(n_up - s), 8'h02);
    chk(8'(n_dn - r), 8'h00);
    pulse_form = 2'h3;
    s = n_up;
    r = n_dn;
    ab(1'b1, 1'b0);
    ab(1'b0, 1'b0);
    chk(8'(n_up + n_dn - s - r), 8'h00);
  endtask : t_pulse
  initial begin
    want = 8'h00;
    input_map = 24'hfac688;
    pulse_form = 2'h1;
    pulse_ref_input = 1'b0;
    sign_ref_input = 1'b0;
    error_detected = 1'b0;
    approach_not_creep = 1'b0;
    reset = 1'b1;
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    go(8'h01);
    chk(8'(motor_power), 8'h01);
    t_fault();
    t_prog();
    t_home();
    t_jog();
    t_misc();
    t_pulse();
    wrap_up();
  end
  // Whole run is about 230 cycles; a hang is cut far beyond that
  initial begin
    repeat (5000) @(posedge core_clk);
    n_fail++;
    wrap_up();
  end
endmodule : tb_indexing_sequence_input_decoder
bind indexing_sequence_input_decoder indexing_sequence_input_decoder_checker i_checker (.core_clk, .reset,
  .general_input_0, .general_input_1, .general_input_2, .general_input_3, .general_input_6, .error_detected,
  .program_mode, .motor_power, .program_run, .program_start, .program_reset, .jog_forward, .fault_clear,
  .fault_output);
